// ==== hdl/pvic_pkg.sv ====
// Package for the process-value input conditioning block.
// Assumes one 50 MHz clock and a classic Wishbone register bus.
package pvic_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_RANGE = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_DROPOUT = 8'h08;
  localparam logic [7:0] OFS_SCALE_LO = 8'h0C;
  localparam logic [7:0] OFS_SCALE_HI = 8'h10;
  localparam logic [7:0] OFS_GAIN = 8'h14;
  localparam logic [7:0] OFS_OFFSET = 8'h18;
  localparam logic [7:0] OFS_SETPOINT = 8'h1C;
  localparam logic [7:0] OFS_PV = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // CONFIG field positions
  localparam int CFG_CJ_EXT = 0;
  localparam int CFG_DP_LSB = 1;
  localparam int CFG_UNDER = 3;
  // STATUS field positions
  localparam int ST_ALM_HI = 0;
  localparam int ST_ALM_LO = 1;
  localparam int ST_CJ_INT = 2;
  localparam int ST_SQRT = 3;
  localparam int ST_DP_LSB = 4;
  // Range-number classes
  localparam logic [6:0] RANGE_TC_FIRST = 7'h01;
  localparam logic [6:0] RANGE_TC_LAST = 7'h28;
  localparam logic [6:0] RANGE_RTD_FIRST = 7'h29;
  localparam logic [6:0] RANGE_RTD_LAST = 7'h44;
  localparam logic [6:0] RANGE_DC_FIRST = 7'h51;
  localparam logic [6:0] RANGE_DC_LAST = 7'h5A;
  localparam logic [6:0] RANGE_FORCE_DP0 = 7'h03;
  localparam logic [6:0] RANGE_UNDER_A = 7'h11;
  localparam logic [6:0] RANGE_UNDER_B = 7'h17;
  // Reset values and limits, percent in tenths, gain in thousandths
  localparam logic [6:0] RST_RANGE = 7'h51;
  localparam logic signed [15:0] RST_SCALE_LO = 16'sh0000;
  localparam logic signed [15:0] RST_SCALE_HI = 16'sh03E8;
  localparam logic [13:0] RST_GAIN = 14'h03E8;
  localparam logic signed [15:0] VAL_MIN = -16'sh07CF;
  localparam logic signed [15:0] VAL_MAX = 16'sh270F;
  localparam logic [13:0] GAIN_MIN = 14'h0001;
  localparam logic [13:0] GAIN_MAX = 14'h270F;
  localparam logic [10:0] DROP_MAX = 11'h3E8;
  localparam logic signed [15:0] PCT_ZERO = 16'sh0000;
  localparam logic signed [15:0] PCT_FULL = 16'sh03E8;
  localparam logic signed [15:0] PCT_LOW_LIM = -16'sh0064;
  localparam logic signed [15:0] PCT_HIGH_LIM = 16'sh044C;
  localparam logic signed [15:0] MV_UNDER = -16'sh01F4;
  localparam logic [10:0] FW_HIDE_MAX = 11'h0E2;
  localparam logic [1:0] DP_MAX = 2'h3;

  // Effective setup seen by the data path
  typedef struct packed {
    logic signed [15:0] scaleLo;
    logic signed [15:0] scaleHi;
    logic [13:0] gain;
    logic signed [15:0] offset;
    logic clampZero;
  } pvic_path_t;
endpackage : pvic_pkg

// ==== hdl/pvic_isqrt.sv ====
// Iterative integer square root, one result bit per clock.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/100ps
`default_nettype none
module pvic_isqrt #(
  parameter int RW = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic start,
  input wire logic [RW-1:0] radicand,
  // Result
  output logic done,
  output logic [RW/2-1:0] root
);
  localparam int HW = RW / 2;
  logic [RW-1:0] rem; // Radicand held for the whole search
  logic [HW-1:0] acc; // Root built so far
  logic [$clog2(HW+1)-1:0] step; // Bits still to find
  logic [HW-1:0] trial;

  // Trial root with the current bit set
  always_comb begin
    trial = acc | (HW'(1) << (step - 1'b1));
  end

  // Bit-serial search, highest bit first
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      step <= '0;
      acc <= '0;
      rem <= '0;
      root <= '0;
    end else if (start) begin
      step <= ($clog2(HW+1))'(HW);
      acc <= '0;
      rem <= radicand;
    end else if (step != '0) begin
      if (RW'(trial) * RW'(trial) <= rem) begin
        acc <= trial;
      end
      step <= step - 1'b1;
      if (step == 1) begin
        root <= (RW'(trial) * RW'(trial) <= rem) ? trial : acc;
        done <= 1'b1;
      end
    end
  end
endmodule : pvic_isqrt
`default_nettype wire

// ==== hdl/pvic_scale.sv ====
// Maps a percent value onto the range, then applies gain and offset.
// Pure logic; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
module pvic_scale
  import pvic_pkg::*;
(
  // Percent in tenths and path setup
  input wire logic signed [15:0] pctIn,
  input wire pvic_path_t path,
  // Range value before and after gain and offset
  output logic signed [15:0] rawOut,
  output logic signed [15:0] corrOut
);
  logic signed [39:0] span;
  logic signed [39:0] mapped;
  logic signed [39:0] corr;

  // Saturate a wide value into sixteen bits
  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sh7FFF) return 16'sh7FFF;
    if (v < -40'sh8000) return -16'sh8000;
    return v[15:0];
  endfunction : sat16

  // Linear scaling, then value times gain plus offset
  always_comb begin
    span = 40'(path.scaleHi) - 40'(path.scaleLo);
    mapped = 40'(path.scaleLo) + (span * 40'(pctIn)) / 40'sd1000;
    corr = (mapped * 40'($signed({1'b0, path.gain}))) / 40'sd1000;
    corr = corr + 40'(path.offset);
    if (path.clampZero && corr < 40'sd0) begin
      corr = '0;
    end
    rawOut = sat16(mapped);
    corrOut = sat16(corr);
  end
endmodule : pvic_scale
`default_nettype wire

// ==== hdl/pvic_conditioner.sv ====
// Process-value input conditioning with a Wishbone register file.
// Assumes a sample in tenths of percent of span with a one-cycle
// valid from logic on clk, and temperature limits from a range table.
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Cold junction: 0 internal, 1 external, reset 0
// - Cold junction setting only for thermocouple ranges
// - Dropout 0 or 0.1..100.0 %; 0 disables
// - Dropout only for DC voltage or current
// - Dropout..100 %: output sqrt(in/100) times 100
// - Above zero, below dropout: output exactly zero
// - At/below 0 or at/above 100 %: pass
// - Decimal position 0..3, reset 0
// - Decimal change moves dependent parameters' point
// - Range 3 forces decimal position 0
// - DC scale limits -1999..9999, reset 0, 1000
// - Temperature ranges: limits read-only, table fixed
// - Under-range type: 0 -10 %FS, 1 -5 mV
// - Under-range type only for ranges 17, 23
// - Under-range hidden for firmware 2.26 or earlier
// - 5 mV on range 23 clamps at zero
// - Alarms on value before gain and offset
// - Limits -10 and +110 %FS; value clamped
module pvic_conditioner
  import pvic_pkg::*;
#(
  parameter logic [10:0] FW_REV = 11'h12C // Arbitrary revision, hundredths
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Sample input
  input wire logic sampleValid,
  input wire logic signed [15:0] samplePct,
  input wire logic signed [15:0] sampleMilliVolt100,
  // Fixed limits of the selected temperature range
  input wire logic signed [15:0] tempRangeLo,
  input wire logic signed [15:0] tempRangeHi,
  // Conditioned outputs
  output logic signed [15:0] pvValue,
  output logic pvValid,
  output logic almHigh,
  output logic almLow,
  output logic cjInternal,
  output logic [1:0] pvDecimals
);
  ////////////////////////////////////////////////////////////////////
  // Setup registers
  logic [6:0] rangeNum; // Selected input range number
  logic cjExternal; // Cold junction handled outside
  logic [1:0] decimalPos; // Written decimal position
  logic underType; // Under-range condition select
  logic [10:0] dropout; // Square-root dropout, tenths
  logic signed [15:0] scaleLo; // DC scaling low
  logic signed [15:0] scaleHi; // DC scaling high
  logic [13:0] pv_gain_factor; // Gain in thousandths
  logic signed [15:0] pv_offset_value; // Offset in units
  logic signed [15:0] setpoint; // Dependent setpoint digits

  // Derived setup
  logic isThermo;
  logic isRtd;
  logic isDc;
  logic underVisible;
  logic underApplies;
  logic [1:0] dpEff;
  logic sqrtOn;
  pvic_path_t path;

  // Bus decode
  logic busWrite;
  logic [31:0] wdRange, wdCfg, wdDrop, wdScale, wdGain, wdOfs, wdSp; // Merged write words

  // Range class check
  function automatic logic inRange(input logic [6:0] v, input logic [6:0] lo,
                                   input logic [6:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : inRange

  // Merge write data into the old word by byte lane
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : laneMerge

  // Legal setting of a signed count
  function automatic logic valOk(input logic [31:0] v);
    return $signed(v[15:0]) >= VAL_MIN && $signed(v[15:0]) <= VAL_MAX;
  endfunction : valOk

  ////////////////////////////////////////////////////////////////////
  // Range class and effective settings
  always_comb begin
    isThermo = inRange(rangeNum, RANGE_TC_FIRST, RANGE_TC_LAST);
    isRtd = inRange(rangeNum, RANGE_RTD_FIRST, RANGE_RTD_LAST);
    isDc = inRange(rangeNum, RANGE_DC_FIRST, RANGE_DC_LAST);
    underVisible = FW_REV > FW_HIDE_MAX;
    underApplies = underVisible && underType
                   && (rangeNum == RANGE_UNDER_A
                       || rangeNum == RANGE_UNDER_B);
    // Range 3 keeps its old integer format
    dpEff = (rangeNum == RANGE_FORCE_DP0) ? 2'h0 : decimalPos;
    sqrtOn = isDc && (dropout != '0);
    // Temperature ranges take the table limits
    path.scaleLo = (isThermo || isRtd) ? tempRangeLo : scaleLo;
    path.scaleHi = (isThermo || isRtd) ? tempRangeHi : scaleHi;
    path.gain = pv_gain_factor;
    path.offset = pv_offset_value;
    path.clampZero = underApplies && rangeNum == RANGE_UNDER_B;
  end

  ////////////////////////////////////////////////////////////////////
  // Wishbone classic handshake, ack one cycle after the request; each write word is
  // the register's old value with the selected lanes replaced
  always_comb begin
    busWrite = cyc_i && stb_i && we_i && !ack_o;
    wdRange = laneMerge({25'h0, rangeNum}, dat_i, sel_i);
    wdCfg = laneMerge({28'h0, underType, decimalPos, cjExternal}, dat_i, sel_i);
    wdDrop = laneMerge({21'h0, dropout}, dat_i, sel_i);
    wdScale = laneMerge((adr_i == OFS_SCALE_LO) ? 32'(scaleLo) : 32'(scaleHi), dat_i, sel_i);
    wdGain = laneMerge({18'h0, pv_gain_factor}, dat_i, sel_i);
    wdOfs = laneMerge(32'(pv_offset_value), dat_i, sel_i);
    wdSp = laneMerge(32'(setpoint), dat_i, sel_i);
  end

  // Acknowledge every access once; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Range number; a new range reloads the DC defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      rangeNum <= RST_RANGE;
    end else if (busWrite && adr_i == OFS_RANGE) begin
      rangeNum <= wdRange[6:0];
    end
  end

  // Configuration bits
  always_ff @(posedge clk) begin
    if (rst) begin
      cjExternal <= 1'b0;
      decimalPos <= 2'h0;
      underType <= 1'b0;
    end else if (busWrite && adr_i == OFS_CONFIG) begin
      if (isThermo) begin
        cjExternal <= wdCfg[CFG_CJ_EXT];
      end
      if (rangeNum != RANGE_FORCE_DP0) begin
        decimalPos <= wdCfg[CFG_DP_LSB +: 2];
      end
      if (underVisible) begin
        underType <= wdCfg[CFG_UNDER];
      end
    end
  end

  // Dropout, accepted only for DC ranges and legal values
  always_ff @(posedge clk) begin
    if (rst) begin
      dropout <= '0;
    end else if (busWrite && adr_i == OFS_DROPOUT && isDc) begin
      if (wdDrop[31:11] == '0 && wdDrop[10:0] <= DROP_MAX) begin
        dropout <= wdDrop[10:0];
      end
    end
  end

  // Scaling limits; a range change restores the defaults
  always_ff @(posedge clk) begin
    if (rst || (busWrite && adr_i == OFS_RANGE)) begin
      scaleLo <= RST_SCALE_LO;
      scaleHi <= RST_SCALE_HI;
    end else if (busWrite && isDc) begin
      if (adr_i == OFS_SCALE_LO && valOk(wdScale)) begin
        scaleLo <= wdScale[15:0];
      end
      if (adr_i == OFS_SCALE_HI && valOk(wdScale)) begin
        scaleHi <= wdScale[15:0];
      end
    end
  end

  // Gain, offset and setpoint
  always_ff @(posedge clk) begin
    if (rst) begin
      pv_gain_factor <= RST_GAIN;
      pv_offset_value <= '0;
      setpoint <= '0;
    end else if (busWrite) begin
      if (adr_i == OFS_GAIN) begin
        if (wdGain[31:14] == '0 && wdGain[13:0] >= GAIN_MIN
            && wdGain[13:0] <= GAIN_MAX) begin
          pv_gain_factor <= wdGain[13:0];
        end
      end
      if (adr_i == OFS_OFFSET && valOk(wdOfs)) begin
        pv_offset_value <= wdOfs[15:0];
      end
      if (adr_i == OFS_SETPOINT) begin
        if (valOk(wdSp)) begin
          setpoint <= wdSp[15:0];
        end
      end
    end
  end

  // Read mux; the setpoint reports the live decimal position
  always_ff @(posedge clk) begin
    if (rst) begin
      dat_o <= '0;
    end else begin
      unique case (adr_i)
        OFS_RANGE: dat_o <= {25'h0, rangeNum};
        OFS_CONFIG: dat_o <= {28'h0, underType & underVisible, dpEff,
                              cjExternal & isThermo};
        OFS_DROPOUT: dat_o <= {21'h0, isDc ? dropout : 11'h0};
        OFS_SCALE_LO: dat_o <= 32'(path.scaleLo);
        OFS_SCALE_HI: dat_o <= 32'(path.scaleHi);
        OFS_GAIN: dat_o <= {18'h0, pv_gain_factor};
        OFS_OFFSET: dat_o <= 32'(pv_offset_value);
        // Digits stay, the implied point follows the PV
        OFS_SETPOINT: dat_o <= {14'h0, dpEff, setpoint};
        OFS_PV: dat_o <= 32'(pvValue);
        OFS_STATUS: dat_o <= {26'h0, dpEff, sqrtOn, cjInternal, almLow, almHigh};
        default: dat_o <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Data path: capture, square root, map, correct
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ROOT = 2'b01,
    ST_MAP = 2'b10
  } pvic_state_t;
  pvic_state_t state;
  logic signed [15:0] pctHold; // Clamped percent of the sample
  logic signed [15:0] pctStage; // stage_output_pct
  logic rootStart;
  logic rootDone;
  logic [9:0] rootVal;
  logic signed [15:0] corrVal;
  logic signed [15:0] stage_input_pct;

  // Percent clamp to -10 ..110 %FS
  always_comb begin
    stage_input_pct = samplePct;
    if (samplePct < PCT_LOW_LIM) begin
      stage_input_pct = PCT_LOW_LIM;
    end else if (samplePct > PCT_HIGH_LIM) begin
      stage_input_pct = PCT_HIGH_LIM;
    end
  end

  pvic_isqrt #(.RW(20)) uRoot (
    .clk(clk),
    .rst(rst),
    .start(rootStart),
    .radicand(20'(pctHold) * 20'd1000),
    .done(rootDone),
    .root(rootVal)
  );

  pvic_scale uScale (
    .pctIn(pctStage),
    .path(path),
    .rawOut(),
    .corrOut(corrVal)
  );

  // One conditioned value per accepted sample, strict stage order
  always_ff @(posedge clk) begin
    rootStart <= 1'b0;
    pvValid <= 1'b0;
    if (rst) begin
      state <= ST_IDLE;
      pctHold <= '0;
      pctStage <= '0;
      pvValue <= '0;
      almHigh <= 1'b0;
      almLow <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (sampleValid) begin
            pctHold <= stage_input_pct;
            pctStage <= stage_input_pct;
            // Alarms look at the sample before any correction
            almHigh <= samplePct > PCT_HIGH_LIM;
            almLow <= underApplies ? (sampleMilliVolt100 < MV_UNDER)
                                   : (samplePct < PCT_LOW_LIM);
            if (!sqrtOn || stage_input_pct <= PCT_ZERO
                || stage_input_pct >= PCT_FULL) begin
              state <= ST_MAP;
            end else if (stage_input_pct < 16'(dropout)) begin
              pctStage <= PCT_ZERO;
              state <= ST_MAP;
            end else begin
              rootStart <= 1'b1;
              state <= ST_ROOT;
            end
          end
        end
        ST_ROOT: begin
          if (rootDone) begin
            pctStage <= 16'(rootVal);
            state <= ST_MAP;
          end
        end
        ST_MAP: begin
          pvValue <= corrVal;
          pvValid <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Registered setup outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      cjInternal <= 1'b0;
      pvDecimals <= 2'h0;
    end else begin
      cjInternal <= isThermo && !cjExternal;
      pvDecimals <= dpEff;
    end
  end
endmodule : pvic_conditioner
`default_nettype wire

// ==== sim/pvic_conditioner_assertions.sv ====
// Concurrent checks on the ports of the process-value conditioner.
// Assumes one clock and samples spaced as the bench spaces them.
`timescale 1ns/100ps
`default_nettype none
module pvic_conditioner_assertions
  import pvic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  // Sample path
  input wire logic sampleValid,
  input wire logic signed [15:0] samplePct,
  input wire logic signed [15:0] sampleMilliVolt100,
  input wire logic signed [15:0] pvValue,
  input wire logic pvValid,
  input wire logic almHigh,
  input wire logic almLow,
  input wire logic cjInternal,
  input wire logic [1:0] pvDecimals
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_only_req: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  ////////////////////////////////////////////////////////////////////////////
  // Sample path; the root path is the slow one: start, ten bits, done, map
  a_pv_latency: assert property (sampleValid |-> ##[2:14] pvValid)
    else $error("conditioned value late");
  a_pv_pulse: assert property (pvValid |=> !pvValid)
    else $error("valid longer than one cycle");
  a_pv_hold: assert property (!pvValid |-> $stable(pvValue))
    else $error("value moved without valid");
  a_alarm_high: assert property (sampleValid && samplePct > PCT_HIGH_LIM |=> almHigh)
    else $error("high alarm missing");
  a_alarm_low: assert property (sampleValid && samplePct < PCT_LOW_LIM
    && sampleMilliVolt100 < MV_UNDER |=> almLow)
    else $error("low alarm missing");
  a_alarm_quiet: assert property (sampleValid && samplePct <= PCT_HIGH_LIM
    && samplePct >= PCT_LOW_LIM && sampleMilliVolt100 >= MV_UNDER
    |=> !almHigh && !almLow)
    else $error("alarm inside limits");
  ////////////////////////////////////////////////////////////////////////////
  // Setup outputs move one cycle after a write is answered
  a_dp_by_write: assert property ($changed(pvDecimals) |-> $past(ack_o) && $past(we_i))
    else $error("decimal position moved alone");
  a_cj_by_write: assert property ($changed(cjInternal) |-> $past(ack_o) && $past(we_i))
    else $error("cold junction moved alone");
endmodule : pvic_conditioner_assertions
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the process-value conditioner.
// Assumes the design's Wishbone slave answers one cycle after a request.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module testbench
  import pvic_pkg::*;
;
  // Stimulus rows: setup, percent in, expected value and alarms
  typedef struct {int drop, lo, hi, gain, ofs, pct, pv; bit ah, al;} pvic_row_t;
  pvic_row_t rows[10] = '{'{0, 0, 1000, 1000, 0, 500, 500, 0, 0},
    '{100, 0, 1000, 1000, 0, 250, 500, 0, 0}, '{100, 0, 1000, 1000, 0, 100, 316, 0, 0},
    '{100, 0, 1000, 1000, 0, 50, 0, 0, 0}, '{100, 0, 1000, 1000, 0, 1000, 1000, 0, 0},
    '{100, 0, 1000, 1000, 0, -50, -50, 0, 0}, '{0, 0, 1000, 2000, 10, 300, 610, 0, 0},
    '{0, -100, 900, 1000, 0, 500, 400, 0, 0}, '{0, 0, 1000, 1000, 0, 1200, 1100, 1, 0},
    '{0, 0, 1000, 1000, 0, -150, -100, 0, 1}};
  // Register reset table, unmapped place last
  logic [7:0] regAdr[10] = '{OFS_RANGE, OFS_CONFIG, OFS_DROPOUT, OFS_SCALE_LO,
    OFS_SCALE_HI, OFS_GAIN, OFS_OFFSET, OFS_SETPOINT, OFS_STATUS, 8'h30};
  logic [31:0] regRst[10] = '{32'h51, 32'h0, 32'h0, 32'h0, 32'h3E8, 32'h3E8,
    32'h0, 32'h0, 32'h0, 32'h0};
  // Design signals
  logic clk, rst, cyc, stb, we, ack, sampleValid, pvValid, almHigh, almLow, cjInternal;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datI, datO, rdData;
  logic signed [15:0] samplePct, sampleMv, tLo, tHi, pvValue;
  logic [1:0] pvDecimals;
  int errors = 0;
  int check_count = 0;

  ////////////////////////////////////////////////////////////////////////////
  pvic_conditioner uut (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO), .ack_o(ack),
    .sampleValid(sampleValid), .samplePct(samplePct), .sampleMilliVolt100(sampleMv),
    .tempRangeLo(tLo), .tempRangeHi(tHi), .pvValue(pvValue), .pvValid(pvValid),
    .almHigh(almHigh), .almLow(almLow), .cjInternal(cjInternal),
    .pvDecimals(pvDecimals));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Watchdog: the whole run needs well under 20000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  // Closing verdict, the single exit of the run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // One classic cycle; held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdData = datO;
    if (n >= 50) errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Registered setup outputs follow one edge after the ack
    @(posedge clk);
  endtask : wb

  // Read one register and compare it
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    wb(1'b0, a, 32'h0);
    `CHK("register", ex, rdData)
  endtask : rd_chk

  // One sample, spaced from the last, then wait for the answer
  task automatic sample(input int p, input int mv);
    int n;
    repeat (14) @(posedge clk);
    sampleValid <= 1'b1;
    samplePct <= 16'(p);
    sampleMv <= 16'(mv);
    @(posedge clk);
    sampleValid <= 1'b0;
    n = 0;
    while (pvValid !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) errors++;
  endtask : sample

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // Everything driven at time zero, reset for 5 cycles
    rst = 1'b1;
    {cyc, stb, we, sampleValid} = 4'h0;
    adr = 8'h00;
    sel = 4'hF;
    datI = 32'h0;
    samplePct = 16'sh0000;
    sampleMv = 16'sh0000;
    tLo = -16'sh0064;
    tHi = 16'sh0384;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Table of ordinary conversions on the reset range
    foreach (rows[i]) begin
      wb(1'b1, OFS_DROPOUT, 32'(rows[i].drop));
      wb(1'b1, OFS_SCALE_LO, 32'(rows[i].lo));
      wb(1'b1, OFS_SCALE_HI, 32'(rows[i].hi));
      wb(1'b1, OFS_GAIN, 32'(rows[i].gain));
      wb(1'b1, OFS_OFFSET, 32'(rows[i].ofs));
      sample(rows[i].pct, 0);
      `CHK("pvValue", 16'(rows[i].pv), pvValue)
      `CHK("almHigh", rows[i].ah, almHigh)
      `CHK("almLow", rows[i].al, almLow)
      $display("test row %0d done", i);
    end
    // Mid-run reset brings every register back
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (regAdr[i]) rd_chk(regAdr[i], regRst[i]);
    `CHK("pvValue", 16'h0000, pvValue)
    $display("test reset done");
    // Out-of-range writes are refused
    wb(1'b1, OFS_SCALE_LO, 32'hFFFFF830);
    rd_chk(OFS_SCALE_LO, 32'h0);
    wb(1'b1, OFS_SCALE_HI, 32'h270F);
    wb(1'b1, OFS_SCALE_HI, 32'h2710);
    rd_chk(OFS_SCALE_HI, 32'h270F);
    wb(1'b1, OFS_GAIN, 32'h0);
    rd_chk(OFS_GAIN, 32'h3E8);
    wb(1'b1, OFS_DROPOUT, 32'h3E9);
    rd_chk(OFS_DROPOUT, 32'h0);
    $display("test limits done");
    // Decimal point moves with dependent setpoint, range 3 forces zero
    wb(1'b1, OFS_CONFIG, 32'h4);
    `CHK("pvDecimals", 2'h2, pvDecimals)
    wb(1'b1, OFS_SETPOINT, 32'h4D2);
    rd_chk(OFS_SETPOINT, 32'h204D2);
    wb(1'b1, OFS_RANGE, 32'h3);
    `CHK("pvDecimals", 2'h0, pvDecimals)
    `CHK("cjInternal", 1'b1, cjInternal)
    wb(1'b1, OFS_DROPOUT, 32'h32);
    rd_chk(OFS_DROPOUT, 32'h0);
    // A temperature range shows the table limit, not the written one
    wb(1'b1, OFS_SCALE_LO, 32'h5);
    rd_chk(OFS_SCALE_LO, 32'hFFFFFF9C);
    wb(1'b1, OFS_CONFIG, 32'h5);
    `CHK("cjInternal", 1'b0, cjInternal)
    `CHK("pvDecimals", 2'h0, pvDecimals)
    $display("test decimals done");
    // Under-range by millivolts on range 23, floor at zero
    wb(1'b1, OFS_RANGE, 32'h17);
    wb(1'b1, OFS_CONFIG, 32'h8);
    sample(-150, -400);
    `CHK("almLow", 1'b0, almLow)
    sample(50, -600);
    `CHK("almLow", 1'b1, almLow)
    `CHK("pvValue", 16'h0000, pvValue)
    wb(1'b1, OFS_CONFIG, 32'h0);
    sample(-150, -400);
    `CHK("almLow", 1'b1, almLow)
    // Back on a DC range the dropout refused on range 3 must not show
    wb(1'b1, OFS_RANGE, 32'h51);
    rd_chk(OFS_DROPOUT, 32'h0);
    $display("test under range done");
    report_and_stop();
  end
endmodule : testbench

// Checker beside the design's top module
bind pvic_conditioner pvic_conditioner_assertions chk (.clk(clk), .rst(rst),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o),
  .sampleValid(sampleValid), .samplePct(samplePct),
  .sampleMilliVolt100(sampleMilliVolt100), .pvValue(pvValue), .pvValid(pvValid),
  .almHigh(almHigh), .almLow(almLow), .cjInternal(cjInternal),
  .pvDecimals(pvDecimals));
`default_nettype wire
